// ===== lane_cfg_pkg.sv
// Contract
// R1 - Software enables exactly the needed pads
// R2 - Clock moves to lane four when requested; the code moves it only when lane four is not a data lane of the width
// R3 - Separate IO feeds lane one into rx zero
// R4 - Pad directions follow the selected lane width
// R5 - Config zero asserts ce0, one asserts ce1
// R6 - Sixteen-bit upper lanes use function code ten
// R7 - Sixteen-bit entry follows documented software order
// R8 - Chip enables only on allowed pads
// R9 - Device config field decodes listed codes
// R10 - Mixed width field decodes listed codes
// R11 - Software sets documented output enable values
// R12 - Disabled pads float, unused rx lanes ignored; lane four drives a moved clock even with its enable bit low
package lane_cfg_pkg;
  // Register byte offsets
  localparam logic [3:0] OFS_DEVICE_CONFIG = 4'h0;
  localparam logic [3:0] OFS_XIP_CONFIG = 4'h4;
  localparam logic [3:0] OFS_PAD_OUTPUT_ENABLE = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hC;
  // Device config field layout
  localparam int DEVCFG_LSB = 0;
  localparam int DEVCFG_W = 5;
  localparam int SEPIO_BIT = 8;
  localparam int CLKD4_BIT = 9;
  localparam int OE_W = 19;
  // Device config codes
  localparam logic [4:0] CFG_SER0 = 5'h01;
  localparam logic [4:0] CFG_SER1 = 5'h02;
  localparam logic [4:0] CFG_DUAL0 = 5'h05;
  localparam logic [4:0] CFG_DUAL1 = 5'h06;
  localparam logic [4:0] CFG_QUAD0 = 5'h09;
  localparam logic [4:0] CFG_FOUR_LANE_CE_ONE = 5'h0A;
  localparam logic [4:0] CFG_OCT0 = 5'h0D;
  localparam logic [4:0] CFG_OCT1 = 5'h0E;
  localparam logic [4:0] CFG_SIXTEEN_LANE_CE_ZERO = 5'h11;
  localparam logic [4:0] CFG_HEX1 = 5'h12;
  // Mixed width codes
  localparam logic [2:0] MIX_NORMAL = 3'h0;
  localparam logic [2:0] MIX_D2 = 3'h1;
  localparam logic [2:0] MIX_AD2 = 3'h3;
  localparam logic [2:0] MIX_D4 = 3'h5;
  localparam logic [2:0] MIX_AD4 = 3'h7;
  // Upper pad group function code
  localparam logic [3:0] FUNC_UPPER = 4'hA;
  // Reset values
  localparam logic [31:0] DEVCFG_RST = 32'h0000_0000;
  localparam logic [31:0] OE_RST = 32'h0000_0000;
  // Lane widths
  typedef enum {W_NONE, W_SER, W_DUAL, W_QUAD, W_OCT, W_HEX} width_t;
endpackage : lane_cfg_pkg

// ===== lane_config.sv
// Decided for this implementation: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Pad and lane configuration for one serial memory port instance
module lane_config
  import lane_cfg_pkg::*;
#(
  parameter bit HEX_CAPABLE = 1'b1 // Only the first instance has sixteen lanes
) (
  input wire logic clk,
  input wire logic rst_b,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // Link side clock and engine outputs
  input wire logic linkClk,
  input wire logic serialClk,
  input wire logic [17:0] engData,
  input wire logic engStrobe,
  // Pad function of upper group, per pad 37..45
  input wire logic [35:0] upperPadFunction,
  // Pads: data 0..17 (8 = strobe, 9..17 = upper), bit18 = clock; oe low drives
  output logic [18:0] padOut,
  output logic [18:0] padOe_b,
  input wire logic [18:0] padIn,
  output logic ce0_b,
  output logic ce1_b,
  // Received lanes to the engine, in link domain
  output logic [17:0] rxLane
);
  // Register state of the bus side
  typedef struct packed {
    logic [31:0] devCfg;
    logic [2:0] mixed;
    logic [OE_W-1:0] padOe;
    logic ack;
    logic err;
    logic [31:0] rdata;
  } bus_t;
  bus_t b_reg;
  bus_t b_next;

  // Link domain state: pad drive and rx capture
  typedef struct packed {
    logic [18:0] out;
    logic [18:0] oe_b;
    logic [17:0] rx;
  } link_t;
  link_t l_reg;
  link_t l_next;

  // Decode the device config code into a lane width
  function automatic width_t width_of(input logic [4:0] code, input bit hex);
    case (code)
      CFG_SER0, CFG_SER1: width_of = W_SER; // see R9
      CFG_DUAL0, CFG_DUAL1: width_of = W_DUAL;
      CFG_QUAD0, CFG_FOUR_LANE_CE_ONE: width_of = W_QUAD;
      CFG_OCT0, CFG_OCT1: width_of = W_OCT;
      CFG_SIXTEEN_LANE_CE_ZERO, CFG_HEX1: width_of = hex ? W_HEX : W_NONE;
      default: width_of = W_NONE;
    endcase
  endfunction : width_of

  // Decode which chip enable a config code names
  function automatic logic [1:0] ce_of(input logic [4:0] code);
    case (code)
      CFG_SER0, CFG_DUAL0, CFG_QUAD0, CFG_OCT0, CFG_SIXTEEN_LANE_CE_ZERO: ce_of = 2'b01; // see R5
      CFG_SER1, CFG_DUAL1, CFG_FOUR_LANE_CE_ONE, CFG_OCT1, CFG_HEX1: ce_of = 2'b10;
      default: ce_of = 2'b00;
    endcase
  endfunction : ce_of

  // Lanes a width may drive; serial drives lane 0 only unless a mixed width code widens it
  function automatic logic [17:0] lane_mask(input width_t w, input logic [2:0] mix);
    case (w)
      W_SER: begin
        // Mixed width widens the data phase lanes, see R10
        case (mix)
          MIX_D2, MIX_AD2: lane_mask = 18'h0_0003;
          MIX_D4, MIX_AD4: lane_mask = 18'h0_000F;
          default: lane_mask = 18'h0_0001;
        endcase
      end
      W_DUAL: lane_mask = 18'h0_0003; // see R4
      W_QUAD: lane_mask = 18'h0_000F;
      W_OCT: lane_mask = 18'h0_00FF;
      W_HEX: lane_mask = 18'h3_FFFF;
      default: lane_mask = 18'h0_0000;
    endcase
  endfunction : lane_mask

  width_t curWidth;
  logic [1:0] ceSel;
  logic [17:0] laneMask;
  logic upperOk;
  logic busHit;
  logic [31:0] rdMux;
  logic [53:0] cfgLink;

  // Upper pad group usable only when every pad has function code ten
  always_comb begin
    upperOk = 1'b1;
    for (int i = 0; i < 9; i++) begin
      if (upperPadFunction[i*4 +: 4] != FUNC_UPPER) begin
        upperOk = 1'b0; // see R6
      end
    end
  end

  // Configuration decode in bus domain
  always_comb begin
    curWidth = width_of(b_reg.devCfg[DEVCFG_LSB +: DEVCFG_W], HEX_CAPABLE);
    ceSel = ce_of(b_reg.devCfg[DEVCFG_LSB +: DEVCFG_W]);
    laneMask = lane_mask(curWidth, b_reg.mixed);
    // Upper lanes and second strobe need the upper pad function
    if (curWidth == W_HEX && !upperOk) begin
      laneMask[17:9] = 9'h000; // see R6
    end
    // Strobe pad used in octal mode
    if (curWidth == W_OCT) begin
      laneMask[8] = 1'b1; // see R4
    end
  end

  // Read mux; unmapped addresses answer with error
  always_comb begin
    busHit = 1'b1;
    case (wb_adr_i)
      OFS_DEVICE_CONFIG: rdMux = b_reg.devCfg;
      OFS_XIP_CONFIG: rdMux = {29'h0000_0000, b_reg.mixed};
      OFS_PAD_OUTPUT_ENABLE: rdMux = {13'h0000, b_reg.padOe};
      OFS_STATUS: rdMux = {25'h000_0000, upperOk, ceSel, 4'(curWidth)};
      default: begin
        rdMux = 32'h0000_0000;
        busHit = 1'b0;
      end
    endcase
  end

  // Bus side next state
  always_comb begin
    b_next = b_reg;
    b_next.ack = 1'b0;
    b_next.err = 1'b0;
    if (wb_cyc_i && wb_stb_i && !b_reg.ack && !b_reg.err) begin
      b_next.ack = busHit;
      b_next.err = !busHit;
      b_next.rdata = rdMux;
      if (wb_we_i && busHit) begin
        for (int k = 0; k < 4; k++) begin
          if (wb_sel_i[k]) begin
            case (wb_adr_i)
              OFS_DEVICE_CONFIG: b_next.devCfg[k*8 +: 8] = wb_dat_i[k*8 +: 8];
              OFS_XIP_CONFIG: if (k == 0) b_next.mixed = wb_dat_i[2:0];
              OFS_PAD_OUTPUT_ENABLE: begin
                // Software selects pads, see R1 and R11
                if (k < 2) begin
                  b_next.padOe[k*8 +: 8] = wb_dat_i[k*8 +: 8];
                end else if (k == 2) begin
                  // Only three enable bits live in the top byte
                  b_next.padOe[OE_W-1:16] = wb_dat_i[OE_W-1:16];
                end
              end
              default: b_next.rdata = rdMux;
            endcase
          end
        end
      end
    end
  end

  // Bus side register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      b_reg <= '{devCfg: DEVCFG_RST, mixed: MIX_NORMAL, padOe: OE_RST[OE_W-1:0],
                 ack: 1'b0, err: 1'b0, rdata: 32'h0000_0000};
    end else begin
      b_reg <= b_next;
    end
  end

  assign wb_ack_o = b_reg.ack;
  assign wb_err_o = b_reg.err;
  assign wb_dat_o = b_reg.rdata;

  // Quasi-static config crosses as levels; software changes it only while idle
  lane_sync #(.W(54)) cfgSync (
    .clk(linkClk),
    .rst_b(rst_b),
    .asyncIn({laneMask, b_reg.padOe[17:0], b_reg.devCfg[CLKD4_BIT],
              b_reg.devCfg[SEPIO_BIT], ceSel, b_reg.padOe[18], 13'h0000}),
    .syncOut(cfgLink)
  );

  logic [17:0] lkMask;
  logic [17:0] lkOe;
  logic lkClkD4;
  logic lkSep;
  logic [1:0] lkCe;
  logic lkD4Ok;
  assign lkMask = cfgLink[53:36];
  assign lkOe = cfgLink[35:18];
  assign lkClkD4 = cfgLink[17];
  assign lkSep = cfgLink[16];
  assign lkCe = cfgLink[15:14];
  // Lane four free only when it is not a data lane
  assign lkD4Ok = lkClkD4 && !lkMask[4];

  logic b_reg_oe_clk; // Clock pad enable, link domain
  logic [18:0] padInRaw;
  logic [17:0] padInSync;

  // Link side pad drive and receive routing
  always_comb begin
    l_next.out = '0;
    l_next.oe_b = '1;
    // Data lanes drive only when enabled by both mask and output enable
    for (int j = 0; j < 18; j++) begin
      l_next.out[j] = engData[j];
      l_next.oe_b[j] = !(lkMask[j] && lkOe[j] && engStrobe); // see R12
    end
    // Clock pad an output when enabled unless the clock moves to lane four, see R4
    l_next.out[18] = serialClk;
    l_next.oe_b[18] = !(b_reg_oe_clk);
    // Relocate clock to lane four in narrow widths
    if (lkD4Ok) begin
      l_next.out[4] = serialClk; // see R2
      l_next.oe_b[4] = 1'b0;
      l_next.oe_b[18] = 1'b1;
    end
    // Receive: unused lanes read as zero
    l_next.rx = padInSync & lkMask & ~(18'(lkD4Ok) << 4); // see R12
    if (lkSep) begin
      l_next.rx[0] = padInSync[1]; // see R3
      l_next.rx[1] = 1'b0;
    end
  end

  // Clock pad follows its own enable bit once a width is selected, see R4 and R12
  assign b_reg_oe_clk = cfgLink[13] && (lkMask != 18'h0_0000);
  assign padInRaw = padIn;

  // Pad inputs come from outside and are synchronised first
  lane_sync #(.W(18)) rxSync (
    .clk(linkClk),
    .rst_b(rst_b),
    .asyncIn(padInRaw[17:0]),
    .syncOut(padInSync)
  );

  // Link side register
  always_ff @(posedge linkClk) begin
    if (!rst_b) begin
      l_reg <= '{out: '0, oe_b: '1, rx: '0};
    end else begin
      l_reg <= l_next;
    end
  end

  assign padOut = l_reg.out;
  assign padOe_b = l_reg.oe_b;
  assign rxLane = l_reg.rx;
  // Chip enables, active low
  assign ce0_b = !(lkCe[0] && engStrobe); // see R5
  assign ce1_b = !(lkCe[1] && engStrobe);

  // Checks in the bus and link domains
  a_ce_exclusive: assert property (@(posedge linkClk) disable iff (!rst_b) // see R5
    !(ce0_b == 1'b0 && ce1_b == 1'b0)) else $error("both chip enables active");
  a_sep_route: assert property (@(posedge linkClk) disable iff (!rst_b) // see R3
    lkSep |=> rxLane[0] == $past(padInSync[1])) else $error("separate io route wrong");
  a_clk_reloc: assert property (@(posedge linkClk) disable iff (!rst_b) // see R2
    lkD4Ok |=> padOe_b[4] == 1'b0 && padOe_b[18]) else $error("clock relocation wrong");
  a_float_off: assert property (@(posedge linkClk) disable iff (!rst_b) // see R12
    !lkOe[5] && !(lkD4Ok) |=> padOe_b[5]) else $error("disabled pad driven");
  a_rx_unused: assert property (@(posedge linkClk) disable iff (!rst_b) // see R12
    !lkMask[7] |=> rxLane[7] == 1'b0) else $error("unused lane not ignored");
  a_dev_decode: assert property (@(posedge clk) disable iff (!rst_b) // see R9
    b_reg.devCfg[4:0] == CFG_FOUR_LANE_CE_ONE |-> ceSel == 2'b10 && curWidth == W_QUAD)
    else $error("quad decode wrong");
  a_mix_decode: assert property (@(posedge clk) disable iff (!rst_b) // see R10
    curWidth == W_SER && b_reg.mixed == MIX_AD4 |-> laneMask[3:0] == 4'hF)
    else $error("mixed decode wrong");
  a_hex_upper: assert property (@(posedge clk) disable iff (!rst_b) // see R6
    curWidth == W_HEX && !upperOk |-> laneMask[17:9] == 9'h000)
    else $error("upper lanes used without function");
  a_oct_dqs: assert property (@(posedge clk) disable iff (!rst_b) // see R4
    curWidth == W_OCT |-> laneMask[8:0] == 9'h1FF) else $error("octal lanes wrong");
  a_bus_ack: assert property (@(posedge clk) disable iff (!rst_b)
    wb_ack_o |=> !wb_ack_o) else $error("ack held");
  c_quad: cover property (@(posedge clk) curWidth == W_QUAD);
  c_hex: cover property (@(posedge clk) curWidth == W_HEX && upperOk);
  c_sep: cover property (@(posedge linkClk) lkSep && engStrobe);
  c_reloc: cover property (@(posedge linkClk) lkD4Ok);
endmodule : lane_config
`default_nettype wire

// ===== lane_device_model.sv
`timescale 1ns/1ps
`default_nettype none
// Far-side memory: answers on every lane the controller releases while either chip enable is low
module lane_device_model (
  input wire logic linkClk,
  input wire logic ce0_b, // Board routes chip enables to allowed pads only
  input wire logic ce1_b,
  input wire logic [18:0] padOut,
  input wire logic [18:0] padOe_b,
  input wire logic [18:0] devData,
  output logic [18:0] padIn
);
  logic [18:0] wander; // Released lanes toggle so a stale level never reads as data
  initial wander = 19'h5_5555;
  // Floating pattern changes every link cycle
  always @(posedge linkClk) begin
    wander <= ~wander;
  end
  // Wire level: controller drive wins, then the selected device, else float
  always_comb begin
    for (int i = 0; i < 19; i++) begin
      if (!padOe_b[i]) begin
        padIn[i] = padOut[i];
      end else if (!(ce0_b && ce1_b)) begin
        padIn[i] = devData[i];
      end else begin
        padIn[i] = wander[i];
      end
    end
  end
endmodule : lane_device_model
`default_nettype wire

// ===== lane_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Two-flop level synchroniser, vectored
module lane_sync #(
  parameter int W = 19
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_t;
  sync_t st_reg;
  sync_t st_next;
  // First stage only feeds the second
  always_comb begin
    st_next.s1 = asyncIn;
    st_next.s2 = st_reg.s1;
  end
  // Synchronous reset register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign syncOut = st_reg.s2;
endmodule : lane_sync
`default_nettype wire

// ===== multilane_spi_pad_lane_config_test.sv
`timescale 1ns/1ps
`default_nettype none
module multilane_spi_pad_lane_config_test;
  import lane_cfg_pkg::*;
  logic clk, rst_b, linkClk, serialClk, engStrobe, cyc, stb, we, ack, werr, ce0_b, ce1_b, e;
  logic [3:0] adr;
  logic [31:0] wdat, rdat, q;
  logic [17:0] engData, rxLane;
  logic [35:0] upFn;
  logic [18:0] padOut, padOe_b, padIn, devData;
  int errCount = 0;
  int compares = 0;
  int cycles = 0;
  localparam logic [4:0] CODES [10] = '{CFG_SER0, CFG_SER1, CFG_DUAL0, CFG_DUAL1, CFG_QUAD0,
    CFG_FOUR_LANE_CE_ONE, CFG_OCT0, CFG_OCT1, CFG_SIXTEEN_LANE_CE_ZERO, CFG_HEX1};
  localparam logic [2:0] MIXES [5] = '{MIX_NORMAL, MIX_D2, MIX_AD2, MIX_D4, MIX_AD4};
  lane_config lane_config_inst (.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .wb_err_o(werr), .linkClk(linkClk), .serialClk(serialClk),
    .engData(engData), .engStrobe(engStrobe), .upperPadFunction(upFn), .padOut(padOut),
    .padOe_b(padOe_b), .padIn(padIn), .ce0_b(ce0_b), .ce1_b(ce1_b), .rxLane(rxLane));
  lane_device_model lane_device_model_inst (.linkClk(linkClk), .ce0_b(ce0_b), .ce1_b(ce1_b),
    .padOut(padOut), .padOe_b(padOe_b), .devData(devData), .padIn(padIn));
  // Bus clock 40 MHz, link clock 6 ns with its own phase
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    linkClk = 1'b0;
    #1.3;
    forever #3 linkClk = ~linkClk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errCount++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", compares, errCount);
    if (errCount == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out
  // One classic cycle; held until ack or err is sampled at a rising edge
  task automatic xfer(input logic [3:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && werr !== 1'b1 && n < 40);
    q = rdat;
    e = werr;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    check(n, 2); // Taken at first edge, ack seen high at the second
  endtask : xfer
  // Config crosses to the link side in a few link edges; ten bus cycles cover it
  task automatic settle();
    repeat (10) @(posedge clk);
  endtask : settle
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errCount++;
      close_out();
    end
  end
  initial begin
    {rst_b, cyc, stb, we, serialClk, engStrobe} = '0;
    {adr, wdat, engData, upFn, devData} = '0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    check(padOe_b, 19'h7_FFFF);
    xfer(OFS_DEVICE_CONFIG, 1'b0, 32'h0000_0000);
    check(q, DEVCFG_RST);
    xfer(OFS_PAD_OUTPUT_ENABLE, 1'b0, 32'h0000_0000);
    check(q, OE_RST);
    // Unmapped place answers with an error; status ignores writes
    xfer(4'h6, 1'b1, 32'hFFFF_FFFF);
    check(e, 1'b1);
    xfer(OFS_STATUS, 1'b1, 32'hFFFF_FFFF);
    xfer(OFS_STATUS, 1'b0, 32'h0000_0000);
    check(q[3:0], 4'h0);
    // Every width code, both chip enables; pads stay off with zero output enables
    engStrobe <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      xfer(OFS_DEVICE_CONFIG, 1'b1, {27'h0, CODES[i]});
      settle();
      check(ce0_b, i[0]);
      check(ce1_b, !i[0]);
      check(padOe_b, 19'h7_FFFF);
      xfer(OFS_STATUS, 1'b0, 32'h0000_0000);
      check(q[3:0], 4'(i / 2 + 1));
    end
    xfer(OFS_DEVICE_CONFIG, 1'b1, 32'h0000_0003);
    xfer(OFS_STATUS, 1'b0, 32'h0000_0000);
    check(q[3:0], 4'h0);
    for (int i = 0; i < 5; i++) begin
      xfer(OFS_XIP_CONFIG, 1'b1, {29'h0, MIXES[i]});
      xfer(OFS_XIP_CONFIG, 1'b0, 32'h0000_0000);
      check(q[2:0], MIXES[i]);
    end
    // Serial: lane 0 drives, lane 1 listens
    engData <= 18'h0_0001;
    xfer(OFS_DEVICE_CONFIG, 1'b1, {27'h0, CFG_SER0});
    xfer(OFS_PAD_OUTPUT_ENABLE, 1'b1, 32'h0000_0101);
    settle();
    check(padOe_b[0], 1'b0);
    check(padOut[0], 1'b1);
    check(padOe_b[1], 1'b1);
    // Separate IO: lane 1 feeds receive lane 0
    devData <= 19'h0_0002;
    xfer(OFS_DEVICE_CONFIG, 1'b1, 32'h0000_0101);
    settle();
    check(rxLane[0], 1'b1);
    check(rxLane[1], 1'b0);
    devData <= 19'h0_0000;
    settle();
    check(rxLane[0], 1'b0);
    // Clock moved to lane 4 in quad; data on lane 4 set opposite
    serialClk <= 1'b1;
    engData <= 18'h0_0000;
    xfer(OFS_DEVICE_CONFIG, 1'b1, 32'h0000_0209);
    xfer(OFS_PAD_OUTPUT_ENABLE, 1'b1, 32'h0000_011F);
    settle();
    check(padOut[4], 1'b1);
    check(padOe_b[4], 1'b0);
    serialClk <= 1'b0;
    engData <= 18'h0_0010;
    settle();
    check(padOut[4], 1'b0);
    // Upper pad group needs function code ten on every pad
    upFn <= {9{FUNC_UPPER}};
    xfer(OFS_DEVICE_CONFIG, 1'b1, {27'h0, CFG_SIXTEEN_LANE_CE_ZERO});
    xfer(OFS_PAD_OUTPUT_ENABLE, 1'b1, 32'h0007_FFFF);
    settle();
    xfer(OFS_STATUS, 1'b0, 32'h0000_0000);
    check(q[6], 1'b1);
    check(padOe_b[17], 1'b0);
    check(padOe_b[18], 1'b0);
    upFn <= {{8{FUNC_UPPER}}, 4'h0};
    settle();
    check(padOe_b[17], 1'b1);
    xfer(OFS_STATUS, 1'b0, 32'h0000_0000);
    check(q[6], 1'b0);
    engStrobe <= 1'b0;
    settle();
    check({ce0_b, ce1_b}, 2'b11);
    close_out();
  end
endmodule : multilane_spi_pad_lane_config_test
`default_nettype wire
